// ==== rtl/adc_ctrl_pkg.sv ====
// ==========================================================
// register map, field layouts, codes and timing
package adc_ctrl_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_RES_HIGH = 8'h08;
  localparam logic [7:0] OFS_RES_LOW  = 8'h0c;
  localparam logic [7:0] OFS_CMP      = 8'h10;
  localparam logic [7:0] OFS_CFG      = 8'h14;
  localparam logic [7:0] OFS_PIN_ONE  = 8'h18;
  localparam logic [7:0] OFS_PIN_TWO  = 8'h1c;
  // channel codes with a fixed meaning
  localparam logic [4:0] CH_EXT_LAST  = 5'h05;
  localparam logic [4:0] CH_EXT_D0    = 5'h08;
  localparam logic [4:0] CH_EXT_D1    = 5'h09;
  localparam logic [4:0] CH_TEMP      = 5'h1a;
  localparam logic [4:0] CH_BANDGAP   = 5'h1b;
  localparam logic [4:0] CH_VREFH     = 5'h1d;
  localparam logic [4:0] CH_OFF       = 5'h1f;
  // conversion clock sources
  localparam logic [1:0] CLK_BUS      = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_LOCAL    = 2'h2;
  localparam logic [1:0] CLK_ALT      = 2'h3;
  // result formats
  localparam logic [1:0] FMT_8        = 2'h0;
  localparam logic [1:0] FMT_12       = 2'h1;
  localparam logic [1:0] FMT_10       = 2'h2;
  // last tick count of a conversion, one less than its length in conversion clock ticks
  localparam logic [4:0] CONV_LAST    = 5'h13;
  // control register one
  typedef struct packed {
    logic       done;
    logic       ien;
    logic       cont;
    logic [4:0] ch;
  } ctrl_one_t;
  // control register two, low nibble reads zero
  typedef struct packed {
    logic       active;
    logic       trig_sel;
    logic       cmp_en;
    logic       cmp_gt;
    logic [3:0] rsvd;
  } ctrl_two_t;
  // clock and format configuration
  typedef struct packed {
    logic       rsvd7;
    logic [1:0] div;
    logic       rsvd4;
    logic [1:0] fmt;
    logic [1:0] src;
  } cfg_t;
  // one-hot converter states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } state_t;
endpackage

// ==== rtl/adc_channel_clock_trigger_ctrl.sv ====
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
// Contract
// - decode 5-bit channel select, 11111 disables
// - reserved channels give undefined results
// - temperature sensor on its own channel
// - four conversion clock sources selectable
// - alternate clock fed from reference clock
// - selected source divided to conversion clock
// - alternate clock kept running in wait
// - trigger select enables counter trigger
// - counter equals modulo starts a conversion
// - trigger works without counter interrupt enable
// - trigger works in run, wait, stop3
// - only two pin enable registers exist
// - right-justified 12, 10 or 8 bit results
// - single or continuous, single returns idle
// - compare less-than or greater-equal gates flag
// - done flag with maskable interrupt request
// - control one write aborts and restarts
// - all-ones channel stops, no extra conversion
// - done cleared by write or low read
module adc_channel_clock_trigger_ctrl
  import adc_ctrl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] analog_sample,
  input  wire logic        local_async_clock,
  input  wire logic        alternate_clock_in,
  input  wire logic [7:0]  rtc_count_value,
  input  wire logic [7:0]  rtc_modulo_value,
  output logic      [4:0]  mux_channel,
  output logic             mux_enable,
  output logic             ext_pin_sel,
  output logic             temp_sensor_sel,
  output logic             conv_active,
  output logic      [15:0] pin_analog_enable_bit,
  output logic             alt_clock_run,
  output logic             conv_irq
);
  // ==========================================================
  // state
  state_t      st_q, st_d;              // converter state
  ctrl_one_t   one_q, one_d;            // channel, mode, flag
  ctrl_two_t   two_q, two_d;            // compare and trigger
  cfg_t        cfg_q, cfg_d;            // clock and format
  logic [11:0] cmp_q, cmp_d;            // compare value
  logic [11:0] res_q, res_d;            // last result
  logic [7:0]  pin1_q, pin1_d;          // pin enables 0..7
  logic [7:0]  pin2_q, pin2_d;          // pin enables 8..15
  logic [4:0]  cnt_q, cnt_d;            // conversion tick count
  logic [2:0]  div_q, div_d;            // clock divider
  logic        half_q, half_d;          // bus clock halved
  logic        pend_q, pend_d;          // pending hw trigger
  logic        match_q, match_d;        // counter match seen
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [4:0]  mux_q, mux_d;
  logic        muxen_q, muxen_d;
  logic        ext_q, ext_d;
  logic        temp_q, temp_d;
  logic        act_q, act_d;
  logic        altrun_q, altrun_d;
  logic        irq_q, irq_d;
  // synchronisers for pins from other domains
  logic [2:0]  loc_s, alt_s;            // [0] first stage only
  logic [11:0] smp_s1, smp_s2;
  // ==========================================================
  // combinational helpers
  logic        acc, wr, rd, wr_one, rd_low, rtc_ev;
  logic        tick, ctick, fin, cmp_ok;
  logic [2:0]  div_lim;
  logic [11:0] res_fmt;

  // a transfer completes when ready is already up
  assign acc    = psel & penable & pready_q;
  assign wr     = acc & pwrite;
  assign rd     = acc & ~pwrite;
  assign wr_one = wr && (paddr == OFS_CTRL_ONE);
  assign rd_low = rd && (paddr == OFS_RES_LOW);
  // counter match makes one pulse per match, independent of its own interrupt enable
  assign rtc_ev = (rtc_count_value == rtc_modulo_value) & ~match_q;
  // divide ratio 1, 2, 4 or 8
  assign div_lim = 3'((4'h1 << cfg_q.div) - 4'h1);
  assign ctick   = tick && (div_q == div_lim);
  assign fin     = (st_q == ST_CONV) && ctick && (cnt_q == CONV_LAST);

  // ==========================================================
  // pick the conversion clock source as an enable in pclk
  // the asynchronous sources count rising edges after sync, so they
  // must run well below pclk or edges are missed
  always_comb
  begin
    case (cfg_q.src)
      CLK_BUS:      tick = 1'b1;
      CLK_BUS_HALF: tick = half_q;
      CLK_LOCAL:    tick = loc_s[1] & ~loc_s[2];
      default:      tick = alt_s[1] & ~alt_s[2];
    endcase
  end

  // ==========================================================
  // format and compare the sampled value
  always_comb
  begin
    case (cfg_q.fmt)
      FMT_12:  res_fmt = smp_s2;
      FMT_10:  res_fmt = {2'h0, smp_s2[11:2]};
      default: res_fmt = {4'h0, smp_s2[11:4]};
    endcase
    // greater-or-equal or less-than the programmed value
    cmp_ok = two_q.cmp_gt ? (res_fmt >= cmp_q) : (res_fmt < cmp_q);
  end

  // ==========================================================
  // next state for registers, converter and bus answer
  always_comb
  begin
    st_d      = st_q;
    one_d     = one_q;
    two_d     = two_q;
    cfg_d     = cfg_q;
    cmp_d     = cmp_q;
    res_d     = res_q;
    pin1_d    = pin1_q;
    pin2_d    = pin2_q;
    cnt_d     = cnt_q;
    pend_d    = pend_q;
    half_d    = ~half_q;
    match_d   = (rtc_count_value == rtc_modulo_value);
    div_d     = div_q;
    prdata_d  = 32'h0;
    pslverr_d = 1'b0;
    // one wait state, then ready for one cycle
    pready_d  = psel & penable & ~pready_q;
    // divider advances on source ticks only
    if (tick)
      div_d = (div_q == div_lim) ? 3'h0 : 3'(div_q + 3'h1);
    // clears first, so a completion below still sets the flag
    if (wr_one || rd_low)
      one_d.done = 1'b0;
    // converter sequencing
    case (st_q)
      ST_IDLE:
      begin
        // a pending trigger starts only on a conversion tick
        if (pend_q && ctick)
        begin
          st_d   = ST_CONV;
          cnt_d  = 5'h00;
          pend_d = 1'b0;
        end
      end
      ST_CONV:
      begin
        if (ctick)
          cnt_d = 5'(cnt_q + 5'h01);
        if (fin)
        begin
          // reserved channels still convert; value is meaningless
          res_d = res_fmt;
          if (!two_q.cmp_en || cmp_ok)
            one_d.done = 1'b1;
          cnt_d = 5'h00;
          if (!one_q.cont)
            st_d = ST_IDLE;
        end
      end
      default:
        st_d = ST_IDLE;
    endcase
    // register writes
    if (wr)
    begin
      case (paddr)
        OFS_CTRL_ONE:
        begin
          one_d.ien  = pwdata[6];
          one_d.cont = pwdata[5];
          one_d.ch   = pwdata[4:0];
          pend_d     = 1'b0;
          cnt_d      = 5'h00;
          // abort; restart at once unless hw triggered or off
          if (pwdata[4:0] == CH_OFF)
            st_d = ST_IDLE;
          else if (!two_q.trig_sel)
            st_d = ST_CONV;
          else
            st_d = ST_IDLE;
        end
        OFS_CTRL_TWO:
        begin
          two_d.trig_sel = pwdata[6];
          two_d.cmp_en   = pwdata[5];
          two_d.cmp_gt   = pwdata[4];
        end
        OFS_CMP:     cmp_d = pwdata[11:0];
        OFS_CFG:
        begin
          cfg_d.div = pwdata[6:5];
          cfg_d.fmt = pwdata[3:2];
          cfg_d.src = pwdata[1:0];
        end
        OFS_PIN_ONE: pin1_d = pwdata[7:0];
        OFS_PIN_TWO: pin2_d = pwdata[7:0];
        default:     ;
      endcase
    end
    // counter trigger arms after the write branch so a match in the
    // same cycle as a control write is not lost; an off write still wins
    if (rtc_ev && two_q.trig_sel && (one_d.ch != CH_OFF))
      pend_d = 1'b1;
    // read data is prepared in the wait state
    if (psel && penable && !pready_q)
    begin
      case (paddr)
        OFS_CTRL_ONE: prdata_d = {24'h0, one_q};
        OFS_CTRL_TWO: prdata_d = {24'h0, st_q == ST_CONV, two_q.trig_sel, two_q.cmp_en, two_q.cmp_gt, 4'h0};
        OFS_RES_HIGH: prdata_d = {28'h0, res_q[11:8]};
        OFS_RES_LOW:  prdata_d = {24'h0, res_q[7:0]};
        OFS_CMP:      prdata_d = {20'h0, cmp_q};
        OFS_CFG:      prdata_d = {24'h0, 1'b0, cfg_q.div, 1'b0, cfg_q.fmt, cfg_q.src};
        OFS_PIN_ONE:  prdata_d = {24'h0, pin1_q};
        OFS_PIN_TWO:  prdata_d = {24'h0, pin2_q};
        default:      pslverr_d = 1'b1;
      endcase
    end
    // outputs, registered so the analog side sees clean levels
    mux_d    = one_q.ch;
    muxen_d  = (one_q.ch != CH_OFF);
    ext_d    = (one_q.ch <= CH_EXT_LAST) || (one_q.ch == CH_EXT_D0) || (one_q.ch == CH_EXT_D1);
    temp_d   = (one_q.ch == CH_TEMP);
    act_d    = (st_d == ST_CONV);
    // ask the clock generator to keep the alternate clock alive in wait
    altrun_d = (cfg_q.src == CLK_ALT) && (one_q.ch != CH_OFF);
    irq_d    = one_q.done & one_q.ien;
  end

  // ==========================================================
  // synchronisers: first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loc_s  <= 3'h0;
      alt_s  <= 3'h0;
      smp_s1 <= 12'h000;
      smp_s2 <= 12'h000;
    end
    else
    begin
      loc_s  <= {loc_s[1:0], local_async_clock};
      alt_s  <= {alt_s[1:0], alternate_clock_in};
      smp_s1 <= analog_sample;
      smp_s2 <= smp_s1;
    end
  end

  // ==========================================================
  // main registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q      <= ST_IDLE;
      one_q     <= '{done: 1'b0, ien: 1'b0, cont: 1'b0, ch: CH_OFF};
      two_q     <= '0;
      cfg_q     <= '0;
      cmp_q     <= 12'h000;
      res_q     <= 12'h000;
      pin1_q    <= 8'h00;
      pin2_q    <= 8'h00;
      cnt_q     <= 5'h00;
      div_q     <= 3'h0;
      half_q    <= 1'b0;
      pend_q    <= 1'b0;
      match_q   <= 1'b0;
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      mux_q     <= CH_OFF;
      muxen_q   <= 1'b0;
      ext_q     <= 1'b0;
      temp_q    <= 1'b0;
      act_q     <= 1'b0;
      altrun_q  <= 1'b0;
      irq_q     <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      one_q     <= one_d;
      two_q     <= two_d;
      cfg_q     <= cfg_d;
      cmp_q     <= cmp_d;
      res_q     <= res_d;
      pin1_q    <= pin1_d;
      pin2_q    <= pin2_d;
      cnt_q     <= cnt_d;
      div_q     <= div_d;
      half_q    <= half_d;
      pend_q    <= pend_d;
      match_q   <= match_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      mux_q     <= mux_d;
      muxen_q   <= muxen_d;
      ext_q     <= ext_d;
      temp_q    <= temp_d;
      act_q     <= act_d;
      altrun_q  <= altrun_d;
      irq_q     <= irq_d;
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign mux_channel           = mux_q;
  assign mux_enable            = muxen_q;
  assign ext_pin_sel           = ext_q;
  assign temp_sensor_sel       = temp_q;
  assign conv_active           = act_q;
  assign pin_analog_enable_bit = {pin2_q, pin1_q};
  assign alt_clock_run         = altrun_q;
  assign conv_irq              = irq_q;

  // ==========================================================
  // checks
  property p_off_stops;
    @(posedge pclk) disable iff (!presetn)
    wr_one && (pwdata[4:0] == CH_OFF) |=> (st_q == ST_IDLE) ##1 (st_q == ST_IDLE);
  endproperty
  a_off_stops: assert property (p_off_stops) else $error("off code did not stop");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    wr_one && (pwdata[4:0] != CH_OFF) && !two_q.trig_sel |=> (st_q == ST_CONV) && (cnt_q == 5'h00);
  endproperty
  a_restart: assert property (p_restart) else $error("write did not restart");

  property p_clr_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_one || rd_low) && !fin |=> !one_q.done;
  endproperty
  a_clr_write: assert property (p_clr_write) else $error("done flag not cleared");

  property p_done_set;
    @(posedge pclk) disable iff (!presetn)
    fin && !two_q.cmp_en |=> one_q.done && (res_q == $past(res_fmt));
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    one_q.done && one_q.ien |=> irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_single;
    @(posedge pclk) disable iff (!presetn)
    fin && !one_q.cont && !wr_one |=> (st_q == ST_IDLE) && !act_q;
  endproperty
  a_single: assert property (p_single) else $error("single did not idle");

  property p_trig;
    @(posedge pclk) disable iff (!presetn)
    rtc_ev && two_q.trig_sel && (one_q.ch != CH_OFF) && !wr_one |=> pend_q || (st_q == ST_CONV);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger lost");

  property p_temp;
    @(posedge pclk) disable iff (!presetn)
    (one_q.ch == CH_TEMP) |=> temp_sensor_sel && mux_enable;
  endproperty
  a_temp: assert property (p_temp) else $error("temp channel not routed");

  property p_pin_two;
    @(posedge pclk) disable iff (!presetn)
    wr && (paddr == OFS_PIN_TWO) |=> pin_analog_enable_bit[15:8] == $past(pwdata[7:0]);
  endproperty
  a_pin_two: assert property (p_pin_two) else $error("pin enable two wrong");

  property p_fmt8;
    @(posedge pclk) disable iff (!presetn)
    fin && (cfg_q.fmt == FMT_8) |=> (res_q[11:8] == 4'h0);
  endproperty
  a_fmt8: assert property (p_fmt8) else $error("8-bit result not justified");
endmodule

// ==== verification/analog_rtc_model.sv ====
`timescale 1ns/1ps
// ==========
// analog core, clock sources and real-time counter seen from the converter
module analog_rtc_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        rtc_run,
  input  wire logic [11:0] level,
  output logic      [11:0] analog_sample,
  output logic             local_async_clock,
  output logic             alternate_clock_in,
  output logic      [7:0]  rtc_count_value,
  output logic      [7:0]  rtc_modulo_value
);
  logic [2:0] div_q; // free-running divider for both slow clocks
  logic [7:0] cnt_q; // counter value

  // the analog level is held steady by the bench during a conversion
  assign analog_sample = level;
  assign rtc_modulo_value = 8'h3f;
  assign rtc_count_value = cnt_q;
  // local clock runs at a quarter of the bus rate
  assign local_async_clock = div_q[1];
  // stands in for the reference clock output; free running, so it keeps going in wait
  assign alternate_clock_in = div_q[2];

  // ==========
  // counter wraps at its modulo; the match is what triggers, no interrupt enable exists here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q <= 3'h0;
      cnt_q <= 8'h00;
    end
    else
    begin
      div_q <= div_q + 3'h1;
      // a parked counter sits at zero, away from the match value
      if (!rtc_run)
        cnt_q <= 8'h00;
      else if (cnt_q == rtc_modulo_value)
        cnt_q <= 8'h00;
      else
        cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// ==== verification/adc_channel_clock_trigger_ctrl_test.sv ====
`timescale 1ns/1ps
// ==========
// register-level bench for the converter control block
module adc_channel_clock_trigger_ctrl_test
  import adc_ctrl_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic        rtc_run = 1'b0;
  logic [11:0] level = 12'habc;
  logic [11:0] sample;
  logic        lclk, aclk;
  logic [7:0]  rcnt, rmod;
  logic [4:0]  mux_channel;
  logic        mux_enable, ext_pin_sel, temp_sensor_sel, conv_active, alt_clock_run, conv_irq;
  logic [15:0] pin_analog_enable_bit;
  int          errors = 0;
  int          checks_done = 0;
  logic [4:0]  c;
  // bandgap code left out: its buffer enable lives in the power controller
  logic [4:0]  codes [9] = '{5'h00, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0a, CH_TEMP, CH_VREFH, CH_OFF};
  logic [1:0]  fmts [4] = '{FMT_12, FMT_10, FMT_8, 2'h3};
  logic [11:0] exps [4] = '{12'habc, 12'h2af, 12'h0ab, 12'h0ab};
  logic [11:0] cvs [4] = '{12'hfff, 12'habc, 12'habc, 12'habd};
  logic [7:0]  c2s [4] = '{8'h30, 8'h30, 8'h20, 8'h20};

  always #5 pclk = ~pclk;

  adc_channel_clock_trigger_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_sample(sample), .local_async_clock(lclk), .alternate_clock_in(aclk), .rtc_count_value(rcnt),
    .rtc_modulo_value(rmod), .mux_channel(mux_channel), .mux_enable(mux_enable), .ext_pin_sel(ext_pin_sel),
    .temp_sensor_sel(temp_sensor_sel), .conv_active(conv_active),
    .pin_analog_enable_bit(pin_analog_enable_bit), .alt_clock_run(alt_clock_run), .conv_irq(conv_irq));

  analog_rtc_model model_u (.pclk(pclk), .presetn(presetn), .rtc_run(rtc_run), .level(level),
    .analog_sample(sample), .local_async_clock(lclk), .alternate_clock_in(aclk),
    .rtc_count_value(rcnt), .rtc_modulo_value(rmod));

  // ==========
  // shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
      errors++;
  endtask

  // poll the done flag; polling control one does not clear it
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[7] !== 1'b1 && n < lim)
    begin
      apb(1'b0, OFS_CTRL_ONE, 32'h0);
      n++;
    end
    check(32'(rd[7]), 32'h1);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========
  // hang guard, well beyond the expected run of a few thousand cycles
  initial
  begin
    repeat (40000) @(posedge pclk);
    errors++;
    summarize();
  end

  // ==========
  // test sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL_ONE, 32'h0);
    check(rd, 32'h1f);
    check(32'({mux_enable, mux_channel}), 32'h1f);
    $display("test reset done");
    // every routing class of the channel field, disable code last
    foreach (codes[k])
    begin
      c = codes[k];
      apb(1'b1, OFS_CTRL_ONE, 32'(c));
      repeat (2) @(posedge pclk);
      check(32'({mux_channel, mux_enable, ext_pin_sel, temp_sensor_sel}), 32'({c, c != CH_OFF,
        c <= CH_EXT_LAST || c == CH_EXT_D0 || c == CH_EXT_D1, c == CH_TEMP}));
    end
    $display("test decode done");
    apb(1'b1, OFS_PIN_ONE, 32'h5a);
    apb(1'b1, OFS_PIN_TWO, 32'hc3);
    @(posedge pclk);
    check(32'(pin_analog_enable_bit), 32'hc35a);
    apb(1'b0, OFS_PIN_ONE, 32'h0);
    check(rd, 32'h5a);
    apb(1'b0, 8'h20, 32'h0);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    $display("test pins done");
    // each source with its own divider and format; interrupt enabled
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, OFS_CFG, 32'(i * 32 + fmts[i] * 4 + i));
      apb(1'b1, OFS_CTRL_ONE, 32'h41);
      repeat (3) @(posedge pclk);
      // alternate clock is requested only while it is the selected source
      check(32'(alt_clock_run), 32'(i == 3));
      wait_done(2000);
      repeat (2) @(posedge pclk);
      check(32'({conv_irq, conv_active}), 32'h2);
      apb(1'b0, OFS_RES_HIGH, 32'h0);
      check(rd, 32'(exps[i][11:8]));
      apb(1'b0, OFS_RES_LOW, 32'h0);
      check(rd, 32'(exps[i][7:0]));
      apb(1'b0, OFS_CTRL_ONE, 32'h0);
      check(rd, 32'h41);
      check(32'(conv_irq), 32'h0);
    end
    apb(1'b1, OFS_CFG, 32'h04);
    $display("test sources done");
    // a second write mid-conversion restarts the count
    apb(1'b1, OFS_CTRL_ONE, 32'h01);
    repeat (8) @(posedge pclk);
    apb(1'b1, OFS_CTRL_ONE, 32'h01);
    repeat (12) @(posedge pclk);
    apb(1'b0, OFS_CTRL_ONE, 32'h0);
    check(rd, 32'h01);
    wait_done(50);
    $display("test abort done");
    // both compare senses at and off the boundary, less-than also just beside it
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, OFS_CMP, 32'(cvs[i]));
      apb(1'b1, OFS_CTRL_TWO, 32'(c2s[i]));
      apb(1'b1, OFS_CTRL_ONE, 32'h01);
      repeat (40) @(posedge pclk);
      apb(1'b0, OFS_CTRL_ONE, 32'h0);
      check(32'({rd[7], conv_active}), 32'(i % 2 * 2));
    end
    apb(1'b1, OFS_CTRL_TWO, 32'h00);
    $display("test compare done");
    // continuous: done returns after a clear, then all-ones stops it cold
    apb(1'b1, OFS_CTRL_ONE, 32'h21);
    wait_done(50);
    apb(1'b0, OFS_RES_LOW, 32'h0);
    wait_done(50);
    apb(1'b1, OFS_CTRL_ONE, 32'h3f);
    repeat (3) @(posedge pclk);
    check(32'(conv_active), 32'h0);
    repeat (60) @(posedge pclk);
    apb(1'b0, OFS_CTRL_ONE, 32'h0);
    check(rd, 32'h3f);
    $display("test continuous done");
    // counter trigger: nothing until the match, interrupt stays masked
    // the bench stays in run mode, so the low-voltage enables are never due
    apb(1'b1, OFS_CTRL_TWO, 32'h40);
    apb(1'b1, OFS_CTRL_ONE, 32'h01);
    repeat (60) @(posedge pclk);
    apb(1'b0, OFS_CTRL_ONE, 32'h0);
    check(32'({rd[7], conv_active}), 32'h0);
    rtc_run <= 1'b1;
    wait_done(80);
    check(32'(conv_irq), 32'h0);
    rtc_run <= 1'b0;
    $display("test trigger done");
    summarize();
  end
endmodule
